/* File: hw/serial_memory_access_cfg.svh */
// Constants shared by both ends of the serial memory link
`ifndef SERIAL_MEMORY_ACCESS_CFG_SVH
`define SERIAL_MEMORY_ACCESS_CFG_SVH
// ====================================================================
// Command bytes
`define OP_SET_LATCH 8'h06
`define OP_CLEAR_LATCH 8'h04
`define OP_MEM_READ 8'h03
`define OP_MEM_WRITE 8'h02
// ====================================================================
// Array geometry and protected block bases
`define ADDR_BITS 15
`define QUARTER_BASE 15'h6000
`define HALF_BASE 15'h4000
`define BP_NONE 2'b00
`define BP_QUARTER 2'b01
`define BP_HALF 2'b10
`define BP_ALL 2'b11
// ====================================================================
// Master timing: clk cycles per half period of the serial clock
`define SCK_HALF_CLKS 4
`define ADDR_BYTES 2
`endif

/* File: hw/serial_memory_access_pkg.sv */
// Types shared by the serial memory link ends
package serial_memory_access_pkg;
   // ====================================================================
   // Device transaction phases
   typedef enum logic [2:0] {PH_OPCODE, PH_ADDR_HI, PH_ADDR_LO, PH_WRITE, PH_READ,
      PH_IGNORE} phase_t;
   // ====================================================================
   // Master sequencer states
   typedef enum logic [1:0] {M_IDLE, M_SHIFT, M_END} master_state_t;
endpackage

/* File: hw/serial_memory_link_if.sv */
// Serial link between the bus master and the memory device
`timescale 1ns/10ps
`default_nettype none
interface serial_memory_link_if;
   logic cs_n;
   logic sck;
   logic si;
   logic hold_n;
   logic wp_n;
   logic so_drive;
   logic so_oe;
   wire so_line;
   // ====================================================================
   // Line resolution; a pause releases the output at once, without a clock edge.
   // A released line shows the inverse of the last bit, so a stray sample shows up.
   assign so_line = (so_oe && hold_n) ? so_drive : !so_drive;
   modport device (input cs_n, input sck, input si, input hold_n, input wp_n,
      output so_drive, output so_oe);
   modport master (output cs_n, output sck, output si, output hold_n, output wp_n,
      input so_line);
endinterface
`default_nettype wire

/* File: hw/memory_device_end.sv */
// Memory device end: serial slave with 32K x 8 array
// Functional notes
// - Master must set write latch before writes
// - Write takes two address bytes, 15 bits
// - Address advances per byte, wraps at top
// - Write byte commits on its eighth bit
// - Data moves most significant bit first
// - Chip select rise ends the transaction
// - Protect level latched at frame start only
// - Read takes two address bytes, 15 bits
// - Serial input ignored after read address
// - Eight clocks shift out one read byte
// - Unlimited write bytes, no page boundaries
// - Pause low suspends, state kept
// - Pause high resumes exactly where stopped
// - Master changes pause only with clock low
// - Sample on rising, drive on falling edge
// - Four command codes, one per frame
// - Any write frame clears the write latch at the next frame's first edge
// - Block protect bits discard protected writes
`include "serial_memory_access_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module memory_device_end
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic block_protect_hi,
   input wire logic block_protect_lo,
   output logic write_latch_flag,
   output logic byte_written,
   serial_memory_link_if.device link
);
   localparam int DEPTH = 1 << `ADDR_BITS;

   logic [7:0] mem [0:DEPTH-1];
   logic frame_end;
   logic wp_meta, wp_sync;
   logic [1:0] bp_reg, bp_meta, bp_sync;
   serial_memory_access_pkg::phase_t phase, next_phase;
   logic [2:0] bit_cnt, next_bit_cnt;
   logic [6:0] shift, next_shift;
   logic [14:0] addr, next_addr;
   logic [7:0] tx, next_tx;
   logic is_write, next_is_write;
   logic frame_wp_n, next_frame_wp_n;
   logic [1:0] frame_bp, next_frame_bp;
   logic latch, next_latch;
   logic pending, next_pending;
   logic commit_tgl, next_commit_tgl;
   logic mem_we;
   logic [7:0] rx;
   logic next_so, next_oe;
   logic wl_meta, tg_meta, tg_sync, tg_last;
   logic next_written;

   // ====================================================================
   // Block protect decode
   function automatic logic is_protected(input logic [14:0] a, input logic [1:0] bp);
      case (bp)
         `BP_QUARTER: is_protected = (a >= `QUARTER_BASE);
         `BP_HALF: is_protected = (a >= `HALF_BASE);
         `BP_ALL: is_protected = 1'b1;
         default: is_protected = 1'b0;
      endcase
   endfunction

   // ====================================================================
   // Crossings into the link domain
   // Protect levels pass two link flops; a frame takes them at its first edge
   always_ff @(posedge link.sck)
   begin
      wp_meta <= link.wp_n;
      wp_sync <= wp_meta;
      bp_meta <= bp_reg;
      bp_sync <= bp_meta;
   end

   // Select high ends the frame at once; while paused, select toggles are ignored
   assign frame_end = link.cs_n & link.hold_n;

   // ====================================================================
   // Receive side, rising edge
   always_comb
   begin
      next_phase = phase;
      next_bit_cnt = bit_cnt;
      next_shift = shift;
      next_addr = addr;
      next_tx = tx;
      next_is_write = is_write;
      next_frame_wp_n = frame_wp_n;
      next_frame_bp = frame_bp;
      next_latch = latch;
      next_pending = pending;
      next_commit_tgl = commit_tgl;
      mem_we = 1'b0;
      rx = {shift, link.si};
      if (link.hold_n && !link.cs_n)
      begin
         next_bit_cnt = bit_cnt + 3'd1;
         next_shift = rx[6:0];
         if (phase == serial_memory_access_pkg::PH_OPCODE && bit_cnt == 3'd0)
         begin
            next_frame_wp_n = wp_sync;
            next_frame_bp = bp_sync;
            if (pending)
            begin
               next_latch = 1'b0;
               next_pending = 1'b0;
            end
         end
         if (bit_cnt == 3'd7)
         begin
            case (phase)
               serial_memory_access_pkg::PH_OPCODE:
               begin
                  next_phase = serial_memory_access_pkg::PH_IGNORE;
                  case (rx)
                     `OP_SET_LATCH: next_latch = 1'b1;
                     `OP_CLEAR_LATCH: next_latch = 1'b0;
                     `OP_MEM_READ: next_phase = serial_memory_access_pkg::PH_ADDR_HI;
                     `OP_MEM_WRITE:
                     begin
                        next_pending = 1'b1;
                        next_is_write = 1'b1;
                        if (latch && frame_wp_n)
                        begin
                           next_phase = serial_memory_access_pkg::PH_ADDR_HI;
                        end
                     end
                     default: next_phase = serial_memory_access_pkg::PH_IGNORE;
                  endcase
               end
               serial_memory_access_pkg::PH_ADDR_HI:
               begin
                  next_addr = {rx[6:0], addr[7:0]};
                  next_phase = serial_memory_access_pkg::PH_ADDR_LO;
               end
               serial_memory_access_pkg::PH_ADDR_LO:
               begin
                  next_addr = {addr[14:8], rx};
                  next_tx = mem[{addr[14:8], rx}];
                  next_phase = is_write ? serial_memory_access_pkg::PH_WRITE
                     : serial_memory_access_pkg::PH_READ;
               end
               serial_memory_access_pkg::PH_WRITE:
               begin
                  // No page limit: the frame runs as long as bytes keep coming
                  mem_we = !is_protected(addr, frame_bp);
                  next_commit_tgl = commit_tgl ^ mem_we;
                  next_addr = addr + 15'h0001;
               end
               serial_memory_access_pkg::PH_READ:
               begin
                  next_addr = addr + 15'h0001;
                  next_tx = mem[addr + 15'h0001];
               end
               default: next_phase = phase;
            endcase
         end
      end
   end

   always_ff @(posedge link.sck or posedge frame_end)
   begin
      if (frame_end)
      begin
         phase <= serial_memory_access_pkg::PH_OPCODE;
         bit_cnt <= 3'd0;
         shift <= 7'h00;
         addr <= 15'h0000;
         tx <= 8'h00;
         is_write <= 1'b0;
         frame_wp_n <= 1'b1;
         frame_bp <= 2'b00;
      end
      else
      begin
         phase <= next_phase;
         bit_cnt <= next_bit_cnt;
         shift <= next_shift;
         addr <= next_addr;
         tx <= next_tx;
         is_write <= next_is_write;
         frame_wp_n <= next_frame_wp_n;
         frame_bp <= next_frame_bp;
      end
   end

   // Latch survives frames, so it lives outside the frame reset.
   // Reset acts at once: the link clock stands still while reset is low,
   // and reset is released with the link idle, well before the next edge.
   always_ff @(posedge link.sck or negedge reset_n)
   begin
      if (!reset_n)
      begin
         latch <= 1'b0;
         pending <= 1'b0;
         commit_tgl <= 1'b0;
      end
      else
      begin
         latch <= next_latch;
         pending <= next_pending;
         commit_tgl <= next_commit_tgl;
      end
   end

   always_ff @(posedge link.sck)
   begin
      if (mem_we)
      begin
         mem[addr] <= rx;
      end
   end

   // ====================================================================
   // Transmit side, falling edge
   always_comb
   begin
      next_so = tx[~bit_cnt];
      next_oe = (phase == serial_memory_access_pkg::PH_READ) && link.hold_n;
   end

   always_ff @(negedge link.sck or posedge frame_end)
   begin
      if (frame_end)
      begin
         link.so_drive <= 1'b0;
         link.so_oe <= 1'b0;
      end
      else
      begin
         link.so_drive <= next_so;
         link.so_oe <= next_oe;
      end
   end

   // ====================================================================
   // User side on clk: protect inputs out, status and commit events back
   always_comb
   begin
      next_written = tg_sync ^ tg_last;
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         bp_reg <= 2'b00;
         wl_meta <= 1'b0;
         write_latch_flag <= 1'b0;
         tg_meta <= 1'b0;
         tg_sync <= 1'b0;
         tg_last <= 1'b0;
         byte_written <= 1'b0;
      end
      else
      begin
         bp_reg <= {block_protect_hi, block_protect_lo};
         wl_meta <= latch;
         write_latch_flag <= wl_meta;
         tg_meta <= commit_tgl;
         tg_sync <= tg_meta;
         tg_last <= tg_sync;
         byte_written <= next_written;
      end
   end
endmodule
`default_nettype wire

/* File: hw/memory_master_end.sv */
// Bus master end: frames commands, addresses and data on the serial link
`include "serial_memory_access_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module memory_master_end
#(
   parameter int HALF_CLKS = `SCK_HALF_CLKS
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic req_valid,
   input wire logic [7:0] req_opcode,
   input wire logic [15:0] req_addr,
   input wire logic [7:0] req_count,
   input wire logic [7:0] wr_data,
   input wire logic pause,
   input wire logic write_protect,
   output logic busy,
   output logic wr_take,
   output logic [7:0] rd_data,
   output logic rd_valid,
   serial_memory_link_if.master link
);
   serial_memory_access_pkg::master_state_t st, next_st;
   logic [7:0] div, next_div;
   logic next_cs_n, next_sck, next_si, next_hold_n, next_busy, next_take, next_rvalid;
   logic [7:0] tx, next_tx, rx, next_rx, opcode, next_opcode, next_rd_data, nbyte;
   logic [15:0] addr, next_addr;
   logic [2:0] bit_cnt, next_bit_cnt;
   logic [1:0] idx, next_idx;
   logic [8:0] left, next_left;
   logic so_meta, so_sync, tick, has_addr;

   // ====================================================================
   // Sequencer
   always_comb
   begin
      next_st = st;
      next_div = div;
      next_cs_n = link.cs_n;
      next_sck = link.sck;
      next_si = link.si;
      next_hold_n = link.hold_n;
      next_busy = busy;
      next_take = 1'b0;
      next_rvalid = 1'b0;
      next_tx = tx;
      next_rx = rx;
      next_opcode = opcode;
      next_rd_data = rd_data;
      next_addr = addr;
      next_bit_cnt = bit_cnt;
      next_idx = idx;
      next_left = left;
      nbyte = 8'h00;
      tick = (div == 8'(HALF_CLKS - 1));
      has_addr = (req_opcode == `OP_MEM_READ) || (req_opcode == `OP_MEM_WRITE);
      case (st)
         serial_memory_access_pkg::M_IDLE:
         begin
            if (req_valid)
            begin
               next_st = serial_memory_access_pkg::M_SHIFT;
               next_busy = 1'b1;
               next_cs_n = 1'b0;
               next_opcode = req_opcode;
               next_addr = req_addr;
               next_tx = req_opcode;
               next_si = req_opcode[7];
               next_bit_cnt = 3'd0;
               next_idx = 2'd0;
               next_left = 9'd1 + (has_addr ? 9'(`ADDR_BYTES) : 9'd0) + {1'b0, req_count};
               next_div = 8'h00;
            end
         end
         serial_memory_access_pkg::M_SHIFT:
         begin
            next_div = tick ? 8'h00 : div + 8'h01;
            if (tick && !link.sck)
            begin
               if (pause == link.hold_n)
               begin
                  next_hold_n = !pause;
               end
               else if (link.hold_n)
               begin
                  next_sck = 1'b1;
                  next_rx = {rx[6:0], so_sync};
               end
            end
            else if (tick)
            begin
               next_sck = 1'b0;
               if (bit_cnt == 3'd7)
               begin
                  next_bit_cnt = 3'd0;
                  if (opcode == `OP_MEM_READ && idx == 2'd3)
                  begin
                     next_rd_data = rx;
                     next_rvalid = 1'b1;
                  end
                  if (left == 9'd1)
                  begin
                     next_st = serial_memory_access_pkg::M_END;
                  end
                  else
                  begin
                     next_left = left - 9'd1;
                     next_idx = (idx == 2'd3) ? idx : idx + 2'd1;
                     if (idx == 2'd0)
                     begin
                        nbyte = addr[15:8];
                     end
                     else if (idx == 2'd1)
                     begin
                        nbyte = addr[7:0];
                     end
                     else if (opcode == `OP_MEM_WRITE)
                     begin
                        nbyte = wr_data;
                        next_take = 1'b1;
                     end
                     next_tx = nbyte;
                     next_si = nbyte[7];
                  end
               end
               else
               begin
                  next_bit_cnt = bit_cnt + 3'd1;
                  next_tx = {tx[6:0], 1'b0};
                  next_si = tx[6];
               end
            end
         end
         serial_memory_access_pkg::M_END:
         begin
            next_div = tick ? 8'h00 : div + 8'h01;
            if (tick)
            begin
               // Second tick gives a deselect gap before the next frame
               if (link.cs_n)
               begin
                  next_st = serial_memory_access_pkg::M_IDLE;
                  next_busy = 1'b0;
               end
               next_cs_n = 1'b1;
            end
         end
         default: next_st = serial_memory_access_pkg::M_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      so_meta <= link.so_line;
      so_sync <= so_meta;
      if (!reset_n)
      begin
         st <= serial_memory_access_pkg::M_IDLE;
         div <= 8'h00;
         link.cs_n <= 1'b1;
         link.sck <= 1'b0;
         link.si <= 1'b0;
         link.hold_n <= 1'b1;
         link.wp_n <= 1'b1;
         busy <= 1'b0;
         wr_take <= 1'b0;
         rd_valid <= 1'b0;
         rd_data <= 8'h00;
         tx <= 8'h00;
         rx <= 8'h00;
         opcode <= 8'h00;
         addr <= 16'h0000;
         bit_cnt <= 3'd0;
         idx <= 2'd0;
         left <= 9'd0;
      end
      else
      begin
         st <= next_st;
         div <= next_div;
         link.cs_n <= next_cs_n;
         link.sck <= next_sck;
         link.si <= next_si;
         link.hold_n <= next_hold_n;
         link.wp_n <= !write_protect;
         busy <= next_busy;
         wr_take <= next_take;
         rd_valid <= next_rvalid;
         rd_data <= next_rd_data;
         tx <= next_tx;
         rx <= next_rx;
         opcode <= next_opcode;
         addr <= next_addr;
         bit_cnt <= next_bit_cnt;
         idx <= next_idx;
         left <= next_left;
      end
   end
endmodule
`default_nettype wire

/* File: dv/serial_memory_access_checker.sv */
// Checker for the serial link between the bus master and the memory device
`include "serial_memory_access_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module serial_memory_access_checker
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   input wire logic hold_n,
   input wire logic so_drive,
   input wire logic so_oe
);
   logic sck_q;
   logic rise;
   logic [15:0] nrise;
   logic [15:0] next_nrise;
   logic [7:0] op;
   logic [7:0] next_op;
   // ====================================================================
   // Frame tracking: sck is a clk flop, so sampling it on clk sees every edge
   assign rise = sck && !sck_q && !cs_n && hold_n;
   always_comb
   begin
      next_nrise = nrise;
      next_op = op;
      if (cs_n)
         next_nrise = 16'h0;
      else if (rise)
      begin
         next_nrise = nrise + 16'h1;
         if (nrise < 16'h8)
            next_op = {op[6:0], si};
      end
   end
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         sck_q <= 1'b0;
         nrise <= 16'h0;
         op <= 8'h0;
      end
      else
      begin
         sck_q <= sck;
         nrise <= next_nrise;
         op <= next_op;
      end
   end
   // ====================================================================
   // Assertions
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   AST_CS_FLOAT: assert property (cs_n |-> !so_oe)
      else $error("Output driven while deselected");
   AST_CMD_FLOAT: assert property (!cs_n && (nrise < 16'd24 || op != `OP_MEM_READ) |-> !so_oe)
      else $error("Output driven outside read data");
   AST_READ_DRIVE: assert property (!cs_n && hold_n && op == `OP_MEM_READ && nrise >= 16'd24
      && $fell(sck) |-> so_oe)
      else $error("Read data not driven after address");
   AST_SO_FALL_ONLY: assert property (so_oe && $changed(so_drive) |-> $fell(sck) && hold_n)
      else $error("Output bit changed off a falling edge");
   AST_HOLD_CHANGE: assert property ($changed(hold_n) |-> !sck)
      else $error("Pause changed with clock high");
   AST_SI_STABLE: assert property (!cs_n && $rose(sck) |-> $stable(si))
      else $error("Serial input moved at rising edge");
   AST_SCK_IDLE: assert property (cs_n |-> !sck)
      else $error("Serial clock high while deselected");
   AST_FRAME_BYTES: assert property ($rose(cs_n) |-> nrise[2:0] == 3'h0 && nrise >= 16'd8)
      else $error("Frame ended mid byte");
   AST_LATCH_FRAME: assert property ($rose(cs_n) && (op == `OP_SET_LATCH ||
      op == `OP_CLEAR_LATCH) |-> nrise == 16'd8)
      else $error("Latch command frame not one byte");
   AST_DESELECT: assert property ($rose(cs_n) |-> cs_n [*4])
      else $error("Deselect too short");
endmodule
`default_nettype wire

/* File: dv/serial_memory_access_tb_top.sv */
// Testbench joining the master end and the device end over the serial link
`include "serial_memory_access_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module serial_memory_access_tb_top;
   logic clk, reset_n, req_valid, pause, write_protect, block_protect_hi, block_protect_lo;
   logic busy, wr_take, rd_valid, write_latch_flag, byte_written;
   logic [7:0] req_opcode, req_count, wr_data, rd_data;
   logic [15:0] req_addr, bw;
   logic [23:0] wdat, rd_acc;
   int fails, cmp_count, hold_at, wp_at;
   serial_memory_link_if link();
   memory_master_end i_memory_master_end (.clk(clk), .reset_n(reset_n), .req_valid(req_valid),
      .req_opcode(req_opcode), .req_addr(req_addr), .req_count(req_count), .wr_data(wr_data),
      .pause(pause), .write_protect(write_protect), .busy(busy), .wr_take(wr_take),
      .rd_data(rd_data), .rd_valid(rd_valid), .link(link));
   memory_device_end i_memory_device_end (.clk(clk), .reset_n(reset_n),
      .block_protect_hi(block_protect_hi), .block_protect_lo(block_protect_lo),
      .write_latch_flag(write_latch_flag), .byte_written(byte_written), .link(link));
   serial_memory_access_checker i_serial_memory_access_checker (.clk(clk), .reset_n(reset_n),
      .cs_n(link.cs_n), .sck(link.sck), .si(link.si), .hold_n(link.hold_n),
      .so_drive(link.so_drive), .so_oe(link.so_oe));
   // ====================================================================
   // Clock, watchdog and capture of the user-side pulses
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial
   begin
      repeat (40000) @(posedge clk);
      fails++;
      test_done;
   end
   always @(posedge clk)
   begin
      #2;
      if (wr_take === 1'b1)
      begin
         wdat = wdat << 8;
         wr_data = wdat[23:16];
      end
      if (rd_valid === 1'b1)
         rd_acc = {rd_acc[15:0], rd_data};
      if (byte_written === 1'b1)
         bw = bw + 16'h1;
   end
   // ====================================================================
   // Tasks
   task chk(input logic [23:0] seen, input logic [23:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Runs one whole frame; pause and protect can be raised at a set cycle in it
   task automatic xfer(input logic [7:0] op, input logic [15:0] addr, input logic [7:0] n,
      input logic [23:0] d);
      int i;
      wdat = d;
      wr_data = d[23:16];
      rd_acc = 24'h0;
      bw = 16'h0;
      req_opcode = op;
      req_addr = addr;
      req_count = n;
      req_valid = 1'b1;
      @(posedge clk);
      #2;
      req_valid = 1'b0;
      i = 0;
      while (busy !== 1'b0)
      begin
         if (i == hold_at)
            pause = 1'b1;
         if (i == hold_at + 60)
            pause = 1'b0;
         if (i == wp_at)
            write_protect = 1'b1;
         @(posedge clk);
         #2;
         i++;
      end
   endtask
   task test_done;
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ====================================================================
   // Main sequence
   initial
   begin
      {fails, cmp_count} = '0;
      hold_at = -1;
      wp_at = -1;
      {req_valid, pause, write_protect, block_protect_hi, block_protect_lo} = '0;
      // A real falling edge, so the link side's reset is seen at once
      reset_n = 1'b1;
      #1;
      reset_n = 1'b0;
      {req_opcode, req_count, wr_data, req_addr, bw, wdat, rd_acc} = '0;
      repeat (8) @(posedge clk);
      #2;
      reset_n = 1'b1;
      xfer(`OP_CLEAR_LATCH, 16'h0, 8'h0, 24'h0);
      chk(write_latch_flag, 24'h0);
      xfer(`OP_SET_LATCH, 16'h0, 8'h0, 24'h0);
      chk(write_latch_flag, 24'h1);
      xfer(`OP_MEM_WRITE, 16'hfffe, 8'h3, 24'h112233);
      chk(bw, 24'h3);
      xfer(`OP_MEM_READ, 16'hfffe, 8'h3, 24'h0);
      chk(rd_acc, 24'h112233);
      chk(write_latch_flag, 24'h0);
      xfer(`OP_MEM_WRITE, 16'h7ffe, 8'h1, 24'h440000);
      chk(bw, 24'h0);
      hold_at = 230;
      xfer(`OP_MEM_READ, 16'h7ffe, 8'h3, 24'h0);
      hold_at = -1;
      chk(rd_acc, 24'h112233);
      // Only 5fff is open under the quarter setting, nothing under the others
      for (int k = 1; k < 4; k++)
      begin
         {block_protect_hi, block_protect_lo} = k[1:0];
         xfer(`OP_SET_LATCH, 16'h0, 8'h0, 24'h0);
         xfer(`OP_MEM_WRITE, 16'h5fff, 8'h2, 24'h667700);
         chk(bw, (k == 1) ? 24'h1 : 24'h0);
      end
      {block_protect_hi, block_protect_lo} = 2'b00;
      xfer(`OP_MEM_READ, 16'h5fff, 8'h1, 24'h0);
      chk(rd_acc, 24'h66);
      xfer(`OP_SET_LATCH, 16'h0, 8'h0, 24'h0);
      wp_at = 100;
      xfer(`OP_MEM_WRITE, 16'h0200, 8'h1, 24'h5a0000);
      wp_at = -1;
      chk(bw, 24'h1);
      xfer(`OP_SET_LATCH, 16'h0, 8'h0, 24'h0);
      xfer(`OP_MEM_WRITE, 16'h0200, 8'h1, 24'ha50000);
      chk(bw, 24'h0);
      write_protect = 1'b0;
      xfer(`OP_MEM_READ, 16'h0200, 8'h1, 24'h0);
      chk(rd_acc, 24'h5a);
      test_done;
   end
endmodule
`default_nettype wire
